// *** include/srb_pkg.sv ***
// Constants and carrier types for the status, event and pad register bank.
// Assumes a serial slave front end that turns bus frames into byte accesses.
package srb_pkg;

	// ---------------------------------------------------------------
	// Register offsets
	// ---------------------------------------------------------------
	localparam logic [7:0] SRB_ADDR_POWER_OSC_CONTROL = 8'h00;
	localparam logic [7:0] SRB_ADDR_PAD_ANALOG_SELECT = 8'h08;
	localparam logic [7:0] SRB_ADDR_PAD_OUTPUT_ENABLE = 8'h09;
	localparam logic [7:0] SRB_ADDR_PAD_OUTPUT_VALUE = 8'h0a;
	localparam logic [7:0] SRB_ADDR_PAD_INPUT_VALUE = 8'h0b;
	localparam logic [7:0] SRB_ADDR_PAD_PULL_CONFIG = 8'h0c;
	localparam logic [7:0] SRB_ADDR_PAD_SLEW_CONFIG = 8'h0d;
	localparam logic [7:0] SRB_ADDR_PRODUCT_VERSION = 8'h91;
	localparam logic [7:0] SRB_ADDR_PART_IDENTIFICATION = 8'h92;
	localparam logic [7:0] SRB_ADDR_EVENT_FLAGS = 8'ha0;
	localparam logic [7:0] SRB_ADDR_CLIP_FLAGS = 8'ha1;
	localparam logic [7:0] SRB_ADDR_LED_SUPPLY_FLAGS = 8'ha2;
	localparam logic [7:0] SRB_ADDR_EVENT_MASK = 8'ha8;
	localparam logic [7:0] SRB_ADDR_MASKED_EVENTS = 8'ha9;

	// ---------------------------------------------------------------
	// Reset values and field positions
	// ---------------------------------------------------------------
	localparam logic [7:0] SRB_RESET_BYTE = 8'h00;
	localparam logic [3:0] SRB_RESET_NIBBLE = 4'h0;
	localparam int SRB_CTRL_REG_EN_BIT = 0;
	localparam int SRB_CTRL_OSC_EN_BIT = 1;
	localparam int SRB_EVT_CONV_DONE = 0;
	localparam int SRB_EVT_SEQ_DONE = 1;
	localparam int SRB_EVT_LTF_DONE = 2;
	localparam int SRB_EVT_CONV_THRESH = 3;
	localparam int SRB_EVT_FIFO_ALMOST = 4;
	localparam int SRB_EVT_FIFO_OVERFLOW = 5;
	localparam int SRB_EVT_CLIP = 6;
	localparam int SRB_EVT_LED_SUPPLY_LOW = 7;
	localparam int SRB_PAD_COUNT = 4;
	localparam int SRB_VERSION_LSB = 3;
	localparam int SRB_ID_LSB = 2;

	// ---------------------------------------------------------------
	// Carrier types
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [3:0] analog_sel;
		logic [3:0] drive_en;
		logic [3:0] drive_val;
		logic [3:0] pull_up;
		logic [3:0] pull_down;
		logic [3:0] fast_slew;
	} srb_pad_cfg_t;

	typedef struct packed {
		logic conv_done;
		logic seq_done;
		logic ltf_done;
		logic fifo_overflow;
		logic [3:0] clip;
		logic [3:0] led_supply_low;
	} srb_evt_t;

endpackage

// *** design/srb_register_bank.sv ***
// Status, event, mask and auxiliary pad register bank with interrupt line.
// Assumes a serial slave front end giving byte accesses synchronous to clk_sys_i.
//
// Notes on behaviour
// R1 - Oscillator enable is control bit 1, resets zero, gates converter functions.
// R2 - Regulator enable is control bit 0; needed before anything beyond register access.
// R3 - Chip enable low holds everything in reset; high allows register accesses.
// R4 - Analog select register holds one bit per pad; bits 7 to 4 reset zero.
// R5 - Host must write the three trim values after analog mode on pads 2, 3.
// R6 - Output enable register enables each pad's driver while its analog select bit is zero; resets zero.
// R7 - Output value drives the pad only while its output enable bit is one.
// R8 - Input register returns sensed pad levels in bits 3 to 0; rest zero.
// R9 - Pull register gives each pad a pulldown and pullup bit pair.
// R10 - Slew register picks default or increased edge rate per pad.
// R11 - Version register holds product version 7:3 and revision 2:0.
// R12 - Identification register holds part code in 7:2, reserved bits 1:0.
// R13 - Event flag register maps the eight events to fixed bit positions.
// R14 - Writing one clears a flag; clip and supply clears also clear their status.
// R15 - FIFO almost-full flag ignores clears and follows the fill level.
// R16 - FIFO overflow flag stays set until software writes one to it.
// R17 - Threshold flag sets when a converter result exceeds the programmed threshold.
// R18 - Clip status reports low and high clip for two signal paths.
// R19 - Supply status bit n reports LED n plus one supply too low.
// R20 - Mask register enables each event bit onto the interrupt; resets zero.
// R21 - Masked register shows each flag ANDed with its enable bit.
// R22 - Interrupt line pulled low while any masked bit is one.
// R23 - Flags latch on single pulses; a set beats a coincident clear.
`timescale 1ns/100ps

module srb_register_bank
	import srb_pkg::*;
#(
	parameter int CONV_W = 14,
	parameter int FIFO_LEVEL_W = 7,
	parameter logic [4:0] PRODUCT_VERSION = 5'h05,
	parameter logic [2:0] REVISION = 3'h0,
	parameter logic [5:0] PART_CODE = 6'h2a,
	parameter logic [1:0] ID_RESERVED = 2'h0
) (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic reset_n_i,
	input wire logic chip_enable_i,
	// Register access from the serial slave
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [7:0] reg_rdata_o,
	// Power control
	output logic regulator_en_o,
	output logic osc_en_o,
	output logic analog_run_ok_o,
	// Event sources
	input wire srb_evt_t evt_i,
	input wire logic conv_valid_i,
	input wire logic [CONV_W-1:0] conv_result_i,
	input wire logic [CONV_W-1:0] conv_threshold_i,
	input wire logic [FIFO_LEVEL_W-1:0] fifo_level_i,
	input wire logic [FIFO_LEVEL_W-1:0] fifo_threshold_i,
	// Auxiliary pads
	input wire logic [3:0] pad_in_i,
	output logic [3:0] pad_out_o,
	output logic [3:0] pad_oe_o,
	output srb_pad_cfg_t pad_cfg_o,
	// Open-drain interrupt line
	output logic int_n_out_o,
	output logic int_n_oe_o
);

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	logic [7:0] control_reg;
	logic [7:0] analog_reg;
	logic [7:0] oe_reg;
	logic [7:0] outval_reg;
	logic [7:0] pull_reg;
	logic [7:0] slew_reg;
	logic [7:0] flags_reg;
	logic [7:0] flags_next;
	logic [3:0] clip_reg;
	logic [3:0] clip_next;
	logic [3:0] led_reg;
	logic [3:0] led_next;
	logic [7:0] mask_reg;
	logic [7:0] rdata_reg;
	logic [7:0] rdata_next;

	// ---------------------------------------------------------------
	// Access decode
	// ---------------------------------------------------------------
	// R3 - chip enable gating
	wire wr_ok = reg_wr_i & chip_enable_i;
	wire rd_ok = reg_rd_i & chip_enable_i;
	wire wr_control = wr_ok & (reg_addr_i == SRB_ADDR_POWER_OSC_CONTROL);
	wire wr_analog = wr_ok & (reg_addr_i == SRB_ADDR_PAD_ANALOG_SELECT);
	wire wr_oe = wr_ok & (reg_addr_i == SRB_ADDR_PAD_OUTPUT_ENABLE);
	wire wr_outval = wr_ok & (reg_addr_i == SRB_ADDR_PAD_OUTPUT_VALUE);
	wire wr_pull = wr_ok & (reg_addr_i == SRB_ADDR_PAD_PULL_CONFIG);
	wire wr_slew = wr_ok & (reg_addr_i == SRB_ADDR_PAD_SLEW_CONFIG);
	wire wr_flags = wr_ok & (reg_addr_i == SRB_ADDR_EVENT_FLAGS);
	wire wr_mask = wr_ok & (reg_addr_i == SRB_ADDR_EVENT_MASK);
	wire [7:0] clr_vec = wr_flags ? reg_wdata_i : SRB_RESET_BYTE;

	// ---------------------------------------------------------------
	// Event flags
	// ---------------------------------------------------------------
	// R17 - threshold compare
	wire conv_over = conv_valid_i & (conv_result_i > conv_threshold_i);
	// R15 - almost-full follows level
	wire fifo_almost = (fifo_level_i >= fifo_threshold_i);
	wire [7:0] set_vec;
	// R13 - event bit mapping
	assign set_vec[SRB_EVT_CONV_DONE] = evt_i.conv_done;
	assign set_vec[SRB_EVT_SEQ_DONE] = evt_i.seq_done;
	assign set_vec[SRB_EVT_LTF_DONE] = evt_i.ltf_done;
	assign set_vec[SRB_EVT_CONV_THRESH] = conv_over;
	assign set_vec[SRB_EVT_FIFO_ALMOST] = 1'b0;
	assign set_vec[SRB_EVT_FIFO_OVERFLOW] = evt_i.fifo_overflow;
	assign set_vec[SRB_EVT_CLIP] = |evt_i.clip;
	assign set_vec[SRB_EVT_LED_SUPPLY_LOW] = |evt_i.led_supply_low;

	always_comb begin
		// R23 - set wins over clear
		// R14 - write one clears
		// R16 - overflow sticky
		flags_next = (flags_reg & ~clr_vec) | set_vec;
		flags_next[SRB_EVT_FIFO_ALMOST] = fifo_almost;
		// R18 - clip status cleared with its flag
		clip_next = (clip_reg & ~{4{clr_vec[SRB_EVT_CLIP]}}) | evt_i.clip;
		// R19 - supply status cleared with its flag
		led_next = (led_reg & ~{4{clr_vec[SRB_EVT_LED_SUPPLY_LOW]}}) | evt_i.led_supply_low;
	end

	// R21 - masked view
	wire [7:0] masked = flags_reg & mask_reg;

	// ---------------------------------------------------------------
	// Read multiplexer
	// ---------------------------------------------------------------
	always_comb begin
		rdata_next = rdata_reg;
		if (rd_ok) begin
			case (reg_addr_i)
				SRB_ADDR_POWER_OSC_CONTROL: rdata_next = control_reg;
				SRB_ADDR_PAD_ANALOG_SELECT: rdata_next = analog_reg;
				SRB_ADDR_PAD_OUTPUT_ENABLE: rdata_next = oe_reg;
				SRB_ADDR_PAD_OUTPUT_VALUE: rdata_next = outval_reg;
				// R8 - sensed levels
				SRB_ADDR_PAD_INPUT_VALUE: rdata_next = {SRB_RESET_NIBBLE, pad_in_i};
				SRB_ADDR_PAD_PULL_CONFIG: rdata_next = pull_reg;
				SRB_ADDR_PAD_SLEW_CONFIG: rdata_next = slew_reg;
				// R11 - version and revision
				SRB_ADDR_PRODUCT_VERSION: rdata_next = {PRODUCT_VERSION, REVISION};
				// R12 - part code
				SRB_ADDR_PART_IDENTIFICATION: rdata_next = {PART_CODE, ID_RESERVED};
				SRB_ADDR_EVENT_FLAGS: rdata_next = flags_reg;
				SRB_ADDR_CLIP_FLAGS: rdata_next = {SRB_RESET_NIBBLE, clip_reg};
				SRB_ADDR_LED_SUPPLY_FLAGS: rdata_next = {SRB_RESET_NIBBLE, led_reg};
				SRB_ADDR_EVENT_MASK: rdata_next = mask_reg;
				SRB_ADDR_MASKED_EVENTS: rdata_next = masked;
				default: rdata_next = SRB_RESET_BYTE;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Register storage
	// ---------------------------------------------------------------
	// R3 - held in reset while disabled
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			control_reg <= SRB_RESET_BYTE;
			analog_reg <= SRB_RESET_BYTE;
			oe_reg <= SRB_RESET_BYTE;
			outval_reg <= SRB_RESET_BYTE;
		end else if (!chip_enable_i) begin
			control_reg <= SRB_RESET_BYTE;
			analog_reg <= SRB_RESET_BYTE;
			oe_reg <= SRB_RESET_BYTE;
			outval_reg <= SRB_RESET_BYTE;
		end else begin
			// R1 - oscillator bit stored
			// R2 - regulator bit stored
			if (wr_control) begin
				control_reg <= reg_wdata_i;
			end
			// R4 - analog select write
			if (wr_analog) begin
				analog_reg <= reg_wdata_i;
			end
			// R6 - output enable write
			if (wr_oe) begin
				oe_reg <= reg_wdata_i;
			end
			if (wr_outval) begin
				outval_reg <= reg_wdata_i;
			end
		end
	end

	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			pull_reg <= SRB_RESET_BYTE;
			slew_reg <= SRB_RESET_BYTE;
			mask_reg <= SRB_RESET_BYTE;
			rdata_reg <= SRB_RESET_BYTE;
		end else if (!chip_enable_i) begin
			pull_reg <= SRB_RESET_BYTE;
			slew_reg <= SRB_RESET_BYTE;
			mask_reg <= SRB_RESET_BYTE;
			rdata_reg <= SRB_RESET_BYTE;
		end else begin
			// R9 - pull write
			if (wr_pull) begin
				pull_reg <= reg_wdata_i;
			end
			// R10 - slew write
			if (wr_slew) begin
				slew_reg <= reg_wdata_i;
			end
			// R20 - mask write
			if (wr_mask) begin
				mask_reg <= reg_wdata_i;
			end
			rdata_reg <= rdata_next;
		end
	end

	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			flags_reg <= SRB_RESET_BYTE;
			clip_reg <= SRB_RESET_NIBBLE;
			led_reg <= SRB_RESET_NIBBLE;
		end else if (!chip_enable_i) begin
			flags_reg <= SRB_RESET_BYTE;
			clip_reg <= SRB_RESET_NIBBLE;
			led_reg <= SRB_RESET_NIBBLE;
		end else begin
			flags_reg <= flags_next;
			clip_reg <= clip_next;
			led_reg <= led_next;
		end
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	assign reg_rdata_o = rdata_reg;
	assign regulator_en_o = control_reg[SRB_CTRL_REG_EN_BIT];
	assign osc_en_o = control_reg[SRB_CTRL_OSC_EN_BIT];
	// R1 - converter needs oscillator
	// R2 - and regulator
	assign analog_run_ok_o = osc_en_o & regulator_en_o;

	genvar p;
	generate
		for (p = 0; p < SRB_PAD_COUNT; p++) begin : g_pad
			// R7 - value only while enabled
			assign pad_oe_o[p] = oe_reg[p] & ~analog_reg[p];
			assign pad_out_o[p] = outval_reg[p] & oe_reg[p];
			// R9 - pulldown on odd bit, pullup on even bit
			assign pad_cfg_o.pull_down[p] = pull_reg[2*p+1];
			assign pad_cfg_o.pull_up[p] = pull_reg[2*p];
		end
	endgenerate
	assign pad_cfg_o.analog_sel = analog_reg[3:0];
	assign pad_cfg_o.drive_en = oe_reg[3:0];
	assign pad_cfg_o.drive_val = outval_reg[3:0];
	assign pad_cfg_o.fast_slew = slew_reg[3:0];

	// R22 - open-drain low while any masked bit set
	assign int_n_out_o = 1'b0;
	assign int_n_oe_o = |masked;

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!reset_n_i);

	sequence s_flag_clear(int b);
		wr_flags && reg_wdata_i[b] && !set_vec[b];
	endsequence

	a_set_beats_clear: assert property ( // R23
		chip_enable_i && |set_vec |=> ((flags_reg & $past(set_vec)) == $past(set_vec)))
		else $error("event lost against a clear");
	a_overflow_sticky: assert property ( // R16
		chip_enable_i && flags_reg[SRB_EVT_FIFO_OVERFLOW] && !(wr_flags
		&& reg_wdata_i[SRB_EVT_FIFO_OVERFLOW]) |=> flags_reg[SRB_EVT_FIFO_OVERFLOW])
		else $error("overflow flag dropped without a clear");
	a_one_clears: assert property ( // R14
		(chip_enable_i and s_flag_clear(SRB_EVT_CONV_DONE)) |=> !flags_reg[SRB_EVT_CONV_DONE])
		else $error("one-write did not clear the flag");
	a_clip_clear_both: assert property ( // R14
		chip_enable_i && wr_flags && reg_wdata_i[SRB_EVT_CLIP] && !(|evt_i.clip)
		|=> clip_reg == 4'h0 && !flags_reg[SRB_EVT_CLIP])
		else $error("clip status survived its clear");
	a_almost_follows: assert property ( // R15
		chip_enable_i |=> flags_reg[SRB_EVT_FIFO_ALMOST] == $past(fifo_almost))
		else $error("almost-full flag not tracking level");
	a_thresh_sets: assert property ( // R17
		chip_enable_i && conv_over |=> flags_reg[SRB_EVT_CONV_THRESH])
		else $error("threshold flag not set");
	a_int_line: assert property ( // R22
		int_n_oe_o == |(flags_reg & mask_reg) && !int_n_out_o)
		else $error("interrupt line disagrees with masked flags");
	a_mask_read: assert property ( // R21
		rd_ok && reg_addr_i == SRB_ADDR_MASKED_EVENTS
		|=> reg_rdata_o == $past(flags_reg & mask_reg))
		else $error("masked register read wrong");
	a_pad_drive: assert property ( // R7
		!oe_reg[0] |-> !pad_oe_o[0] && !pad_out_o[0])
		else $error("pad driven while disabled");
	a_disable_reset: assert property ( // R3
		!chip_enable_i |=> control_reg == 8'h00 && mask_reg == 8'h00 && flags_reg == 8'h00)
		else $error("state not cleared while disabled");
	a_input_read: assert property ( // R8
		rd_ok && reg_addr_i == SRB_ADDR_PAD_INPUT_VALUE
		|=> reg_rdata_o == {4'h0, $past(pad_in_i)})
		else $error("pad input read wrong");

endmodule

// *** bench/srb_host_model.sv ***
// Host model: issues byte accesses on the register strobe port of the bank.
// Assumes a 100 ns system clock; inputs change at the falling edge only.
`timescale 1ns/100ps

module srb_host_model (
	// Clock and read data
	input wire logic clk_sys_i,
	input wire logic [7:0] reg_rdata_i,
	// Access strobes
	output logic [7:0] reg_addr_o,
	output logic [7:0] reg_wdata_o,
	output logic reg_wr_o,
	output logic reg_rd_o
);
	initial begin
		reg_addr_o = 8'h00;
		reg_wdata_o = 8'h00;
		reg_wr_o = 1'b0;
		reg_rd_o = 1'b0;
	end

	// -------------------------------------------------------------
	// Access tasks
	// -------------------------------------------------------------
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_sys_i);
		reg_addr_o = a;
		reg_wdata_o = d;
		reg_wr_o = 1'b1;
		@(negedge clk_sys_i);
		reg_wr_o = 1'b0;
		reg_addr_o = ~a;
		reg_wdata_o = ~d;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk_sys_i);
		reg_addr_o = a;
		reg_rd_o = 1'b1;
		@(negedge clk_sys_i);
		reg_rd_o = 1'b0;
		reg_addr_o = ~a;
		d = reg_rdata_i;
	endtask

	task automatic power_up();
		wr(8'h00, 8'h03);
	endtask

	task automatic trim_pads();
		wr(8'hc6, 8'h47);
		wr(8'hc2, 8'h0c);
		wr(8'hc3, 8'h0c);
	endtask
endmodule

// *** bench/srb_register_bank_tb.sv ***
// Testbench for the register bank: register, pad, event and interrupt checks.
// Assumes the host model drives the access port and the bench drives the rest.
`timescale 1ns/100ps

module srb_register_bank_tb;
	import srb_pkg::*;
	// Identity values are arbitrary.
	localparam logic [4:0] VER = 5'h0b;
	localparam logic [2:0] REV = 3'h2;
	localparam logic [5:0] PART = 6'h15;
	logic clk_sys_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic chip_enable_i = 1'b1;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	logic reg_wr, reg_rd, reg_en, osc_en, run_ok, int_out, int_oe;
	srb_evt_t evt = '0;
	logic conv_valid = 1'b0;
	logic [13:0] conv_result = 14'h0000;
	logic [13:0] conv_thr = 14'h0100;
	logic [6:0] fifo_level = 7'h00;
	logic [6:0] fifo_thr = 7'h30;
	logic [3:0] pad_in = 4'h0;
	logic [3:0] pad_out, pad_oe;
	srb_pad_cfg_t pad_cfg;
	int n_mismatch = 0;
	int checks = 0;
	logic [7:0] adr [12] = '{8'h00, 8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'ha0,
		8'ha1, 8'ha2, 8'ha8, 8'ha9};
	logic [7:0] rw [7] = '{8'h00, 8'h08, 8'h09, 8'h0a, 8'h0c, 8'h0d, 8'ha8};
	logic [7:0] d;

	initial begin
		forever #50 clk_sys_i = ~clk_sys_i;
	end

	srb_host_model host (.clk_sys_i(clk_sys_i), .reg_rdata_i(reg_rdata), .reg_addr_o(reg_addr),
		.reg_wdata_o(reg_wdata), .reg_wr_o(reg_wr), .reg_rd_o(reg_rd));

	srb_register_bank #(.PRODUCT_VERSION(VER), .REVISION(REV), .PART_CODE(PART)) dut (
		.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .chip_enable_i(chip_enable_i),
		.reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
		.reg_rdata_o(reg_rdata), .regulator_en_o(reg_en), .osc_en_o(osc_en),
		.analog_run_ok_o(run_ok), .evt_i(evt), .conv_valid_i(conv_valid),
		.conv_result_i(conv_result), .conv_threshold_i(conv_thr), .fifo_level_i(fifo_level),
		.fifo_threshold_i(fifo_thr), .pad_in_i(pad_in), .pad_out_o(pad_out), .pad_oe_o(pad_oe),
		.pad_cfg_o(pad_cfg), .int_n_out_o(int_out), .int_n_oe_o(int_oe));

	// -------------------------------------------------------------
	// Check helpers
	// -------------------------------------------------------------
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] v;
		host.rd(a, v);
		chk($sformatf("register %h", a), exp, v);
	endtask

	task automatic pulse(input srb_evt_t e);
		@(negedge clk_sys_i);
		evt = e;
		@(negedge clk_sys_i);
		evt = '0;
	endtask

	task automatic conv(input logic [13:0] r);
		@(negedge clk_sys_i);
		conv_result = r;
		conv_valid = 1'b1;
		@(negedge clk_sys_i);
		conv_valid = 1'b0;
	endtask

	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clk_sys_i);
		n_mismatch++;
		stop_test();
	end

	// -------------------------------------------------------------
	// Main sequence
	// -------------------------------------------------------------
	initial begin
		repeat (8) @(negedge clk_sys_i);
		reset_n_i = 1'b1;
		foreach (adr[i]) rchk(adr[i], 8'h00);
		chk("interrupt enable", 8'h00, {7'h0, int_oe});
		rchk(8'h91, {VER, REV});
		host.rd(8'h92, d);
		chk("part code", {PART, 2'b00}, d & 8'hfc);
		$display("test reset values done");
		foreach (rw[i]) host.wr(rw[i], 8'h5a);
		foreach (rw[i]) rchk(rw[i], 8'h5a);
		chk("power outputs", 8'h02, {5'h0, run_ok, osc_en, reg_en});
		host.power_up();
		chk("power outputs", 8'h07, {5'h0, run_ok, osc_en, reg_en});
		host.wr(8'ha8, 8'h00);
		host.wr(8'h09, 8'h0f);
		host.wr(8'h0a, 8'h05);
		host.wr(8'h08, 8'h04);
		host.trim_pads();
		host.wr(8'h0c, 8'h9c);
		host.wr(8'h0d, 8'h0a);
		chk("pad out", 8'h05, {4'h0, pad_out});
		chk("pad oe", 8'h0b, {4'h0, pad_oe});
		chk("pull down", 8'h0a, {4'h0, pad_cfg.pull_down});
		chk("pull up", 8'h06, {4'h0, pad_cfg.pull_up});
		chk("slew", 8'h0a, {4'h0, pad_cfg.fast_slew});
		chk("analog", 8'h04, {4'h0, pad_cfg.analog_sel});
		chk("drive enable", 8'h0f, {4'h0, pad_cfg.drive_en});
		chk("drive value", 8'h05, {4'h0, pad_cfg.drive_val});
		pad_in = 4'ha;
		host.wr(8'h0b, 8'hff);
		rchk(8'h0b, 8'h0a);
		rchk(8'h55, 8'h00);
		$display("test pads done");
		pulse(srb_evt_t'{conv_done: 1'b1, seq_done: 1'b1, ltf_done: 1'b1, fifo_overflow: 1'b1,
			default: '0});
		rchk(8'ha0, 8'h27);
		chk("interrupt masked off", 8'h00, {7'h0, int_oe});
		host.wr(8'ha8, 8'h21);
		rchk(8'ha9, 8'h21);
		chk("interrupt", 8'h01, {6'h0, int_out, int_oe});
		host.wr(8'ha0, 8'h07);
		rchk(8'ha0, 8'h20);
		chk("interrupt", 8'h01, {7'h0, int_oe});
		host.wr(8'ha0, 8'h20);
		chk("interrupt released", 8'h00, {7'h0, int_oe});
		conv(14'h0100);
		rchk(8'ha0, 8'h00);
		conv(14'h0101);
		rchk(8'ha0, 8'h08);
		host.wr(8'ha0, 8'h08);
		fifo_level = 7'h30;
		host.wr(8'ha0, 8'h10);
		rchk(8'ha0, 8'h10);
		fifo_level = 7'h2f;
		rchk(8'ha0, 8'h00);
		$display("test event flags done");
		pulse(srb_evt_t'{clip: 4'h5, led_supply_low: 4'h9, default: '0});
		rchk(8'ha1, 8'h05);
		rchk(8'ha2, 8'h09);
		fork
			host.wr(8'ha0, 8'h40);
			pulse(srb_evt_t'{clip: 4'h2, conv_done: 1'b1, default: '0});
		join
		rchk(8'ha1, 8'h02);
		rchk(8'ha0, 8'hc1);
		host.wr(8'ha0, 8'hc1);
		rchk(8'ha1, 8'h00);
		rchk(8'ha2, 8'h00);
		rchk(8'ha0, 8'h00);
		$display("test clip and supply done");
		host.wr(8'ha8, 8'hff);
		@(negedge clk_sys_i);
		chip_enable_i = 1'b0;
		host.wr(8'h09, 8'h03);
		chip_enable_i = 1'b1;
		rchk(8'ha8, 8'h00);
		rchk(8'h09, 8'h00);
		chk("power outputs", 8'h00, {5'h0, run_ok, osc_en, reg_en});
		$display("test chip enable done");
		stop_test();
	end
endmodule
